// >>> ude_pkg.sv
// Notes on behaviour
// [RULE1] after init the function is enabled, powered, only bus reset interrupt on; here CTRL resets to 0x00, leaving the function disabled
// [RULE2] before a bus reset no bus traffic is answered
// [RULE3] bus reset sets up descriptors and endpoints, enables sources, default
// [RULE4] set address in default state moves to addressed, new address only
// [RULE5] set configuration moves to configured and the value is kept
// [RULE6] firmware loads an in buffer only when free, flips toggle, sets owner
// [RULE7] loading a buffer not yet collected reports failure to the caller
// [RULE8] receive copies out buffer only when host data arrived, else fails
// [RULE9] setup data lands in endpoint zero out buffer, status, done event
// [RULE10] in token on an engine buffer sends its data, then done event
// [RULE11] stall bit set rejects host transactions until firmware clears it; here setup is still accepted and a bus reset also clears the bit
// [RULE12] clearing attach disconnects; detach is held about 50 ms
// [RULE13] bus idle flag sets after 3 ms without bus activity
// [RULE14] on idle the function suspends and the activity event is enabled
// [RULE15] activity event rises on first bus transition to wake the processor
// [RULE16] bus errors raise an error event, never an automatic detach
// [RULE17] firmware clears error counters, enables regulator and reset event
// [RULE18] application waits for the configured state before transfers
// [RULE19] a 64 byte shared memory holds the descriptor table and buffers
// [RULE20] enumeration state sits in the low two bits at 0x197
// [RULE21] engine clears ownership when it completes a transaction
package ude_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [8:0] REG_CTRL   = 9'h190;
    localparam logic [8:0] REG_STAT   = 9'h191;
    localparam logic [8:0] REG_IEN    = 9'h192;
    localparam logic [8:0] REG_XSTAT  = 9'h193;
    localparam logic [8:0] REG_ADDR   = 9'h194;
    localparam logic [8:0] REG_CONFIG = 9'h195;
    localparam logic [8:0] REG_ERRCNT = 9'h196;
    localparam logic [8:0] REG_ENUM   = 9'h197;
    localparam logic [8:0] REG_EPCTL  = 9'h198;
    localparam logic [8:0] REG_RAM    = 9'h1c0;
    localparam int         RAM_BYTES  = 64;
    localparam int         BDT_BYTES  = 24;
    localparam int         BUF_BYTES  = 8;
    localparam int         N_DESC     = 6;
    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int CTRL_FUNC_EN = 0;
    localparam int CTRL_ATTACH  = 1;
    localparam int CTRL_IDLE    = 2;
    localparam int CTRL_SUSP    = 3;
    localparam int CTRL_XCVR    = 4;
    localparam int EV_RESET     = 0;
    localparam int EV_DONE      = 1;
    localparam int EV_ERR       = 2;
    localparam int EV_ACT       = 3;
    localparam int EV_STALL     = 4;
    localparam int BD_OWN       = 7;
    localparam int BD_DATA1     = 6;
    localparam int EPCTL_STALL  = 0;
    localparam logic [7:0] CTRL_RST     = 8'h00;
    localparam logic [7:0] IEN_RST      = 8'h01;
    localparam logic [7:0] IEN_ON_RESET = 8'h17;
    localparam logic [1:0] ENUM_POWERED    = 2'h0;
    localparam logic [1:0] ENUM_DEFAULT    = 2'h1;
    localparam logic [1:0] ENUM_ADDRESSED  = 2'h2;
    localparam logic [1:0] ENUM_CONFIGURED = 2'h3;
    // ****************************************
    // bus side codes and timing
    // ****************************************
    localparam logic [2:0] RX_SETUP = 3'h1;
    localparam logic [2:0] RX_OUT   = 3'h2;
    localparam logic [2:0] RX_IN    = 3'h3;
    localparam logic [2:0] RX_DATA  = 3'h4;
    localparam logic [2:0] RX_RESET = 3'h5;
    localparam logic [2:0] RX_ERROR = 3'h6;
    localparam logic [1:0] HS_ACK   = 2'h1;
    localparam logic [1:0] HS_NAK   = 2'h2;
    localparam logic [1:0] HS_STALL = 2'h3;
    localparam int CLK_MHZ        = 250;
    localparam int IDLE_TIME_US   = 3000;
    localparam int DETACH_TIME_US = 50000;
    localparam int IDLE_CYCLES    = IDLE_TIME_US * CLK_MHZ;
    localparam int DETACH_CYCLES  = DETACH_TIME_US * CLK_MHZ;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX} ude_eng_state_t;
    typedef struct packed {
        logic       valid;
        logic [2:0] kind;
        logic [6:0] addr;
        logic [1:0] ep;
        logic [7:0] data;
        logic       last;
    } ude_rx_t;
    typedef struct packed {
        logic       valid;
        logic       last;
        logic       empty;
        logic       data1;
        logic [7:0] data;
        logic       hs_valid;
        logic [1:0] hs;
    } ude_tx_t;
endpackage

// >>> ude_core.sv
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module ude_core #(
    parameter int unsigned IDLE_CYCLES   = ude_pkg::IDLE_CYCLES,
    parameter int unsigned DETACH_CYCLES = ude_pkg::DETACH_CYCLES
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // register port
    input  wire logic [8:0]       addr_i,
    input  wire logic [7:0]       wdata_i,
    input  wire logic             we_i,
    input  wire logic             re_i,
    output logic      [7:0]       rdata_o,
    // bus side
    input  wire ude_pkg::ude_rx_t rx_i,
    output ude_pkg::ude_tx_t      tx_o,
    // pins and events
    output logic                  attach_o,
    output logic                  xcvr_en_o,
    output logic                  irq_o
);
    localparam int IW = $clog2(IDLE_CYCLES + 1);
    localparam int DW = $clog2(DETACH_CYCLES + 1);

    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_sync_q;
    logic       rst_n;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ****************************************
    // state
    // ****************************************
    ude_pkg::ude_eng_state_t state_q, state_d;
    logic [7:0]    ctrl_q, ctrl_d, stat_q, stat_d, ien_q, ien_d;
    logic [7:0]    xstat_q, config_q, errcnt_q, rdata_d;
    logic [6:0]    addr_q;
    logic [1:0]    enum_q, enum_d;
    logic [7:0]    epctl_q [4];
    logic [7:0]    mem_q [ude_pkg::RAM_BYTES];
    logic [2:0]    desc_q, desc_d;
    logic [3:0]    ptr_q, ptr_d;
    logic [IW-1:0] idle_q;
    logic [DW-1:0] det_q, det_d;
    ude_pkg::ude_tx_t tx_d;

    // ****************************************
    // register decode
    // ****************************************
    wire wr_ctrl = we_i && addr_i == ude_pkg::REG_CTRL;
    wire wr_stat = we_i && addr_i == ude_pkg::REG_STAT;
    wire wr_ien  = we_i && addr_i == ude_pkg::REG_IEN;
    wire wr_addr = we_i && addr_i == ude_pkg::REG_ADDR;
    wire wr_cfg  = we_i && addr_i == ude_pkg::REG_CONFIG;
    wire wr_err  = we_i && addr_i == ude_pkg::REG_ERRCNT;
    wire is_ep   = addr_i[8:2] == ude_pkg::REG_EPCTL[8:2];
    wire wr_ep   = we_i && is_ep;
    wire is_ram  = addr_i >= ude_pkg::REG_RAM;
    wire wr_ram  = we_i && is_ram;
    wire [5:0] ram_ix = addr_i[5:0];

    // ****************************************
    // bus events
    // ****************************************
    wire func_en = ctrl_q[ude_pkg::CTRL_FUNC_EN];
    wire susp    = ctrl_q[ude_pkg::CTRL_SUSP];
    wire act     = rx_i.valid;
    wire bus_rst = act && rx_i.kind == ude_pkg::RX_RESET && func_en;
    wire err_ev  = act && rx_i.kind == ude_pkg::RX_ERROR && func_en;
    wire rx_data = act && rx_i.kind == ude_pkg::RX_DATA;
    wire is_setup = rx_i.kind == ude_pkg::RX_SETUP;
    wire is_in    = rx_i.kind == ude_pkg::RX_IN;
    wire rx_tok = act && (is_setup || is_in || rx_i.kind == ude_pkg::RX_OUT);
    wire [6:0] my_addr = (enum_q == ude_pkg::ENUM_DEFAULT) ? 7'h00 : addr_q;

    // ****************************************
    // token decode
    // ****************************************
    wire [2:0] tok_desc = {rx_i.ep, is_in};
    wire [7:0] tok_stat = mem_q[{1'b0, tok_desc, 2'h0}];
    wire tok_own = tok_stat[ude_pkg::BD_OWN];
    // silent until the first bus reset and to foreign addresses [RULE2] [RULE4]
    wire tok_ok = rx_tok && state_q == ude_pkg::ST_IDLE && func_en && !susp
        && enum_q != ude_pkg::ENUM_POWERED && rx_i.addr == my_addr
        && rx_i.ep != 2'h3;
    // stalled endpoints refuse all but setup [RULE11]
    wire tok_stall = tok_ok && !is_setup
        && epctl_q[rx_i.ep][ude_pkg::EPCTL_STALL];
    wire tok_acc = tok_ok && !tok_stall && (is_setup || tok_own);
    wire tok_nak = tok_ok && !tok_stall && !is_setup && !tok_own;

    // ****************************************
    // current descriptor
    // ****************************************
    wire [5:0] cur_ix = {1'b0, desc_q, 2'h0};
    wire [7:0] cur_stat = mem_q[cur_ix];
    wire [7:0] cur_cnt8 = mem_q[cur_ix | 6'h01];
    wire [7:0] cur_adr = mem_q[cur_ix | 6'h02];
    wire [3:0] cur_cnt = (cur_cnt8 > 8'h08) ? 4'h8 : cur_cnt8[3:0];
    wire [7:0] buf_sum = cur_adr + {4'h0, ptr_q};
    wire [5:0] buf_ix = buf_sum[5:0];
    wire tx_end = cur_cnt == 4'h0 || ptr_q + 4'h1 >= cur_cnt;
    wire rx_fin = state_q == ude_pkg::ST_RX && rx_data && rx_i.last
        && !bus_rst;
    wire tx_fin = state_q == ude_pkg::ST_TX && tx_end && !bus_rst;
    wire done_ev = rx_fin || tx_fin;
    wire rx_store = state_q == ude_pkg::ST_RX && rx_data && ptr_q != 4'h8;

    // ****************************************
    // idle and detach
    // ****************************************
    wire idle_hit = func_en && !act && idle_q == IW'(IDLE_CYCLES - 1);
    wire detach_start = wr_ctrl && !wdata_i[ude_pkg::CTRL_ATTACH]
        && ctrl_q[ude_pkg::CTRL_ATTACH];
    // first bus transition wakes the processor [RULE15]
    wire act_ev = act && (susp || ien_q[ude_pkg::EV_ACT]);

    // ****************************************
    // engine
    // ****************************************
    always_comb begin
        state_d = state_q;
        ptr_d   = ptr_q;
        desc_d  = desc_q;
        case (state_q)
            ude_pkg::ST_IDLE: begin
                if (tok_acc) begin
                    state_d = is_in ? ude_pkg::ST_TX : ude_pkg::ST_RX;
                    ptr_d   = 4'h0;
                    desc_d  = tok_desc;
                end
            end
            ude_pkg::ST_RX: begin
                if (bus_rst || err_ev) begin
                    state_d = ude_pkg::ST_IDLE;
                end else if (rx_data) begin
                    ptr_d = ptr_q + {3'h0, ptr_q != 4'h8};
                    if (rx_i.last) begin
                        state_d = ude_pkg::ST_IDLE;
                    end
                end
            end
            ude_pkg::ST_TX: begin
                ptr_d = ptr_q + 4'h1;
                if (bus_rst || tx_end) begin
                    state_d = ude_pkg::ST_IDLE;
                end
            end
            default: state_d = ude_pkg::ST_IDLE;
        endcase
    end

    always_comb begin
        tx_d = '0;
        if (state_q == ude_pkg::ST_TX && !bus_rst) begin
            tx_d.valid = 1'b1;                         // [RULE10]
            tx_d.last  = tx_end;
            tx_d.empty = cur_cnt == 4'h0;
            tx_d.data1 = cur_stat[ude_pkg::BD_DATA1];
            tx_d.data  = mem_q[buf_ix];
        end
        tx_d.hs_valid = rx_fin || tok_stall || tok_nak;
        if (tok_stall) begin
            tx_d.hs = ude_pkg::HS_STALL;               // [RULE11]
        end else if (tok_nak) begin
            tx_d.hs = ude_pkg::HS_NAK;
        end else if (rx_fin) begin
            tx_d.hs = ude_pkg::HS_ACK;
        end
    end

    // ****************************************
    // register next values
    // ****************************************
    always_comb begin
        ctrl_d = wr_ctrl ? wdata_i : ctrl_q;
        ctrl_d[7:5] = 3'h0;
        // idle flag and suspend after quiet time [RULE13] [RULE14]
        ctrl_d[ude_pkg::CTRL_IDLE] = idle_hit
            || (ctrl_q[ude_pkg::CTRL_IDLE] && !act);
        ctrl_d[ude_pkg::CTRL_SUSP] = idle_hit || (susp && !act);
        stat_d = stat_q & ~(wr_stat ? wdata_i : 8'h00);
        stat_d[ude_pkg::EV_RESET] = stat_d[ude_pkg::EV_RESET] || bus_rst;
        stat_d[ude_pkg::EV_DONE]  = stat_d[ude_pkg::EV_DONE] || done_ev;
        stat_d[ude_pkg::EV_ERR]   = stat_d[ude_pkg::EV_ERR] || err_ev;
        stat_d[ude_pkg::EV_ACT]   = stat_d[ude_pkg::EV_ACT] || act_ev;
        stat_d[ude_pkg::EV_STALL] = stat_d[ude_pkg::EV_STALL] || tok_stall;
        ien_d = wr_ien ? wdata_i : ien_q;
        if (idle_hit) begin
            ien_d[ude_pkg::EV_ACT] = 1'b1;             // [RULE14]
        end
        if (detach_start) begin
            ien_d = ude_pkg::IEN_RST;
        end
        if (bus_rst) begin
            ien_d = ien_d | ude_pkg::IEN_ON_RESET;     // [RULE3]
        end
        enum_d = enum_q;
        if (wr_addr && wdata_i[6:0] != 7'h00
            && enum_q == ude_pkg::ENUM_DEFAULT) begin
            enum_d = ude_pkg::ENUM_ADDRESSED;          // [RULE4]
        end
        if (wr_cfg && enum_q[1]) begin
            enum_d = (wdata_i != 8'h00) ? ude_pkg::ENUM_CONFIGURED
                                        : ude_pkg::ENUM_ADDRESSED; // [RULE5]
        end
        if (detach_start) begin
            enum_d = ude_pkg::ENUM_POWERED;
        end
        if (bus_rst) begin
            enum_d = ude_pkg::ENUM_DEFAULT;            // [RULE3]
        end
        det_d = (det_q != '0) ? det_q - DW'(1) : '0;
        if (detach_start) begin
            det_d = DW'(DETACH_CYCLES);                // [RULE12]
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (addr_i == ude_pkg::REG_CTRL) begin
            rdata_d = ctrl_q;
        end else if (addr_i == ude_pkg::REG_STAT) begin
            rdata_d = stat_q;
        end else if (addr_i == ude_pkg::REG_IEN) begin
            rdata_d = ien_q;
        end else if (addr_i == ude_pkg::REG_XSTAT) begin
            rdata_d = xstat_q;
        end else if (addr_i == ude_pkg::REG_ADDR) begin
            rdata_d = {1'b0, addr_q};
        end else if (addr_i == ude_pkg::REG_CONFIG) begin
            rdata_d = config_q;
        end else if (addr_i == ude_pkg::REG_ERRCNT) begin
            rdata_d = errcnt_q;
        end else if (addr_i == ude_pkg::REG_ENUM) begin
            rdata_d = {6'h00, enum_q};                 // [RULE20]
        end else if (is_ep) begin
            rdata_d = epctl_q[addr_i[1:0]];
        end else if (is_ram) begin
            rdata_d = mem_q[ram_ix];
        end
    end

    // ****************************************
    // flip-flops
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= ude_pkg::ST_IDLE;
            desc_q   <= 3'h0;
            ptr_q    <= 4'h0;
            ctrl_q   <= ude_pkg::CTRL_RST;
            stat_q   <= 8'h00;
            ien_q    <= ude_pkg::IEN_RST;              // [RULE1]
            enum_q   <= ude_pkg::ENUM_POWERED;         // [RULE1]
            det_q    <= '0;
            idle_q   <= '0;
            rdata_o  <= 8'h00;
            tx_o     <= '0;
            attach_o <= 1'b0;
            irq_o    <= 1'b0;
        end else begin
            state_q  <= state_d;
            desc_q   <= desc_d;
            ptr_q    <= ptr_d;
            ctrl_q   <= ctrl_d;
            stat_q   <= stat_d;
            ien_q    <= ien_d;
            enum_q   <= enum_d;
            det_q    <= det_d;
            idle_q   <= (act || !func_en) ? '0
                      : (idle_q == IW'(IDLE_CYCLES)) ? idle_q
                      : idle_q + IW'(1);
            rdata_o  <= re_i ? rdata_d : 8'h00;
            tx_o     <= tx_d;
            // held off while the detach timer runs [RULE12]
            attach_o <= ctrl_d[ude_pkg::CTRL_ATTACH] && det_d == '0;
            irq_o    <= |(stat_q & ien_q);
        end
    end
    assign xcvr_en_o = ctrl_q[ude_pkg::CTRL_XCVR];

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            xstat_q  <= 8'h00;
            config_q <= 8'h00;
            addr_q   <= 7'h00;
            errcnt_q <= 8'h00;
            for (int e = 0; e < 4; e++) begin
                epctl_q[e] <= 8'h00;
            end
        end else begin
            if (done_ev) begin
                xstat_q <= {5'h00, desc_q};            // [RULE9]
            end
            if (wr_cfg) begin
                config_q <= wdata_i;                   // [RULE5]
            end
            if (bus_rst) begin
                addr_q <= 7'h00;
            end else if (wr_addr) begin
                addr_q <= wdata_i[6:0];
            end
            // errors are counted and raise the error event, attach is left alone [RULE16]
            if (err_ev && errcnt_q != 8'hff) begin
                errcnt_q <= errcnt_q + 8'h01;
            end else if (wr_err) begin
                errcnt_q <= 8'h00;
            end
            for (int e = 0; e < 4; e++) begin
                if (bus_rst) begin
                    epctl_q[e] <= 8'h00;               // [RULE3]
                end else if (wr_ep && addr_i[1:0] == 2'(e)) begin
                    epctl_q[e] <= wdata_i;             // [RULE11]
                end
            end
        end
    end

    // ****************************************
    // shared buffer memory
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < ude_pkg::RAM_BYTES; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else begin
            if (wr_ram) begin
                mem_q[ram_ix] <= wdata_i;              // [RULE19]
            end
            if (rx_store) begin
                mem_q[buf_ix] <= rx_i.data;            // [RULE9]
            end
            if (rx_fin) begin
                mem_q[cur_ix | 6'h01] <= {4'h0, ptr_d};
            end
            if (done_ev) begin
                mem_q[cur_ix] <= {1'b0, cur_stat[6:0]}; // [RULE21]
            end
            if (bus_rst) begin
                for (int i = 0; i < ude_pkg::N_DESC; i++) begin
                    mem_q[4*i]   <= 8'h00;             // [RULE3]
                    mem_q[4*i+1] <= 8'(ude_pkg::BUF_BYTES);
                    mem_q[4*i+2] <= 8'(ude_pkg::BDT_BYTES
                        + ude_pkg::BUF_BYTES * ((i < 4) ? i : 4));
                end
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_setup_rx;
        tok_acc && is_setup && rx_i.ep == 2'h0;
    endsequence
    sequence s_done_marked;
        stat_q[ude_pkg::EV_DONE] && !mem_q[cur_ix][ude_pkg::BD_OWN];
    endsequence

    AST_POWERED_SILENT: assert property ( // [RULE2]
        enum_q == ude_pkg::ENUM_POWERED && state_q == ude_pkg::ST_IDLE
        |=> !tx_o.valid && !tx_o.hs_valid)
        else $error("traffic answered before bus reset");
    AST_RESET_DEFAULT: assert property ( // [RULE3]
        bus_rst |=> enum_q == ude_pkg::ENUM_DEFAULT
        && ien_q[ude_pkg::EV_DONE] && addr_q == 7'h00)
        else $error("bus reset did not reach default state");
    AST_ADDRESSED: assert property ( // [RULE4]
        wr_addr && wdata_i[6:0] != 7'h00 && !bus_rst && !detach_start
        && enum_q == ude_pkg::ENUM_DEFAULT
        |=> enum_q == ude_pkg::ENUM_ADDRESSED)
        else $error("set address not taken");
    AST_CONFIG_KEPT: assert property ( // [RULE5]
        wr_cfg |=> config_q == $past(wdata_i))
        else $error("configuration value lost");
    AST_SETUP_DONE: assert property ( // [RULE9]
        s_setup_rx ##[1:9] (rx_fin && !wr_stat && desc_q == 3'h0)
        |=> s_done_marked and (xstat_q == 8'h00))
        else $error("setup completion not reported");
    AST_IN_DONE: assert property ( // [RULE10]
        tx_fin && !wr_stat
        |=> s_done_marked and (tx_o.valid && tx_o.last))
        else $error("in completion not reported");
    AST_STALL: assert property ( // [RULE11]
        tok_ok && !is_setup && epctl_q[rx_i.ep][ude_pkg::EPCTL_STALL]
        |=> tx_o.hs_valid && tx_o.hs == ude_pkg::HS_STALL
        && state_q == ude_pkg::ST_IDLE)
        else $error("stalled endpoint answered");
    AST_DETACH_HOLD: assert property ( // [RULE12]
        detach_start |=> !attach_o [*8])
        else $error("detach not held");
    AST_IDLE_FLAG: assert property ( // [RULE13]
        func_en && !act && !wr_ctrl && idle_q == IW'(IDLE_CYCLES - 1)
        |=> ctrl_q[ude_pkg::CTRL_IDLE] && susp)
        else $error("idle flag missed");
    AST_WAKE: assert property ( // [RULE15]
        susp && act && !wr_stat |=> !susp && stat_q[ude_pkg::EV_ACT])
        else $error("activity did not resume function");
    AST_ERR_NO_DETACH: assert property ( // [RULE16]
        err_ev && !wr_ctrl && !wr_stat |=> stat_q[ude_pkg::EV_ERR]
        && $stable(ctrl_q[ude_pkg::CTRL_ATTACH]))
        else $error("error handling wrong");
    AST_ENUM_READ: assert property ( // [RULE20]
        re_i && addr_i == ude_pkg::REG_ENUM
        |=> rdata_o[1:0] == $past(enum_q))
        else $error("enumeration state misread");
endmodule

// >>> ude_host_model.sv
`timescale 1ns/1ns
module ude_host_model (
    // clock
    input  wire logic        clk_i,
    // bus events to the device
    output ude_pkg::ude_rx_t rx_o
);
    initial rx_o = '0;
    // one event a cycle, driven just after the edge
    task automatic send(input logic [2:0] k, input logic [6:0] a,
                        input logic [1:0] ep, input logic [8:0] dl);
        @(posedge clk_i);
        rx_o <= {1'b1, k, a, ep, dl};
    endtask
    // released lines show the inverse, never the last value
    task automatic rel();
        @(posedge clk_i);
        rx_o <= {1'b0, ~rx_o[20:0]};
    endtask
endmodule

// >>> tb_usb_device_endpoint_core.sv
`timescale 1ns/1ns
module tb_usb_device_endpoint_core;
    // ****************************************
    // signals and instances
    // ****************************************
    logic             clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             we = 1'b0;
    logic             re = 1'b0;
    logic [8:0]       addr = '0;
    logic [7:0]       wdata = '0;
    logic [7:0]       rdata;
    ude_pkg::ude_rx_t rx;
    ude_pkg::ude_tx_t tx;
    logic             att;
    logic             xcv;
    logic             irq;
    logic [8:0]       h;
    logic [8:0]       d;
    int               err_count = 0;
    int               total_checks = 0;
    int               cyc = 0;
    always #2 clk = ~clk;
    ude_core #(.IDLE_CYCLES(40), .DETACH_CYCLES(16)) i_ude_core (
        .clk_i(clk), .reset_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
        .we_i(we), .re_i(re), .rdata_o(rdata), .rx_i(rx), .tx_o(tx),
        .attach_o(att), .xcvr_en_o(xcv), .irq_o(irq));
    ude_host_model i_ude_host_model (.clk_i(clk), .rx_o(rx));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [8:0] g, e, input string n);
        total_checks++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", n, e, g);
            err_count++;
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e, string n);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 chk({1'b0, rdata}, {1'b0, e}, n);
    endtask
    task automatic obs();
        h = '0;
        d = '0;
        repeat (6) begin
            @(negedge clk);
            if (tx.hs_valid === 1'b1) h = {7'h01, tx.hs};
            if (tx.valid === 1'b1 && d == '0) d = {tx.data1, tx.data};
        end
    endtask
    task automatic tok(input logic [2:0] k, logic [6:0] a, logic [1:0] ep);
        i_ude_host_model.send(k, a, ep, '0);
        i_ude_host_model.rel();
        obs();
    endtask
    task automatic t_enum();
        rd(ude_pkg::REG_ENUM, 8'h00, "enum");
        rd(ude_pkg::REG_IEN, 8'h01, "ien");
        wr(ude_pkg::REG_CTRL, 8'h13);
        tok(ude_pkg::RX_IN, 7'h00, 2'h0);
        chk(h, 9'h000, "early");
        chk({8'h00, xcv}, 9'h001, "xcvr");
        tok(ude_pkg::RX_RESET, 7'h00, 2'h0);
        rd(ude_pkg::REG_ENUM, 8'h01, "dflt");
        rd(ude_pkg::REG_IEN, 8'h17, "ien2");
        rd(9'h1c5, 8'h08, "cnt");
        rd(9'h1c6, 8'h20, "bufa");
        $display("test enum done");
    endtask
    task automatic t_xfer();
        wr(ude_pkg::REG_STAT, 8'hff);
        i_ude_host_model.send(ude_pkg::RX_SETUP, '0, '0, '0);
        i_ude_host_model.send(ude_pkg::RX_DATA, '0, '0, 9'h14a);
        i_ude_host_model.send(ude_pkg::RX_DATA, '0, '0, 9'h0b5);
        i_ude_host_model.rel();
        obs();
        chk(h, 9'h005, "ack");
        rd(9'h1d8, 8'ha5, "buf");
        rd(9'h1c1, 8'h02, "cnt2");
        rd(9'h1c0, 8'h00, "own");
        rd(ude_pkg::REG_XSTAT, 8'h00, "xs");
        rd(ude_pkg::REG_STAT, 8'h02, "done");
        chk({8'h00, irq}, 9'h001, "irq");
        rd(9'h1c4, 8'h00, "free");
        wr(9'h1e0, 8'h3c);
        wr(9'h1c5, 8'h01);
        wr(9'h1c4, 8'hc0);
        tok(ude_pkg::RX_IN, 7'h00, 2'h0);
        chk(d, 9'h13c, "indat");
        rd(9'h1c4, 8'h40, "own2");
        rd(ude_pkg::REG_XSTAT, 8'h01, "xs2");
        $display("test xfer done");
    endtask
    task automatic t_addr();
        wr(ude_pkg::REG_ADDR, 8'h05);
        rd(ude_pkg::REG_ENUM, 8'h02, "adr");
        tok(ude_pkg::RX_IN, 7'h00, 2'h0);
        chk(h, 9'h000, "old");
        tok(ude_pkg::RX_IN, 7'h05, 2'h0);
        chk(h, 9'h006, "new");
        wr(ude_pkg::REG_CONFIG, 8'h01);
        rd(ude_pkg::REG_ENUM, 8'h03, "cfg");
        rd(ude_pkg::REG_CONFIG, 8'h01, "cval");
        wr(9'h199, 8'h01);
        tok(ude_pkg::RX_IN, 7'h05, 2'h1);
        chk(h, 9'h007, "stl");
        wr(9'h199, 8'h00);
        tok(ude_pkg::RX_IN, 7'h05, 2'h1);
        chk(h, 9'h006, "unstl");
        $display("test addr done");
    endtask
    task automatic t_idle();
        wr(ude_pkg::REG_STAT, 8'hff);
        tok(ude_pkg::RX_ERROR, 7'h00, 2'h0);
        rd(ude_pkg::REG_STAT, 8'h04, "err");
        chk({8'h00, att}, 9'h001, "att");
        rd(ude_pkg::REG_ERRCNT, 8'h01, "ecnt");
        repeat (40) @(posedge clk);
        rd(ude_pkg::REG_CTRL, 8'h1f, "idle");
        rd(ude_pkg::REG_IEN, 8'h1f, "ienact");
        tok(ude_pkg::RX_IN, 7'h7f, 2'h0);
        rd(ude_pkg::REG_STAT, 8'h0c, "act");
        rd(ude_pkg::REG_CTRL, 8'h13, "wake");
        wr(ude_pkg::REG_CTRL, 8'h11);
        rd(ude_pkg::REG_ENUM, 8'h00, "pwr");
        chk({8'h00, att}, 9'h000, "det");
        wr(ude_pkg::REG_CTRL, 8'h13);
        rd(ude_pkg::REG_CTRL, 8'h13, "reatt");
        chk({8'h00, att}, 9'h000, "held");
        repeat (12) @(posedge clk);
        #1 chk({8'h00, att}, 9'h001, "back");
        $display("test idle done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ****************************************
    // sequence and timeout
    // ****************************************
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_enum();
        t_xfer();
        t_addr();
        t_idle();
        summarize();
    end
endmodule
